// *** design/bacr_pkg.sv ***
package bacr_pkg;
  // byte register offsets on the expansion bus
  localparam logic [4:0] OFS_DAC_FIRST  = 5'h04;
  localparam logic [4:0] OFS_DAC_LAST   = 5'h0B;
  localparam logic [4:0] OFS_PORT_CTRL  = 5'h13;
  localparam logic [4:0] OFS_FLOAT_CTRL = 5'h14;
  localparam logic [4:0] OFS_ADC_CMD    = 5'h15;
  localparam logic [4:0] OFS_TRIG_EN    = 5'h16;
  localparam logic [4:0] OFS_PIN_CHANGE = 5'h17;
  localparam logic [4:0] OFS_DAC_REF    = 5'h18;

  // field positions
  localparam int FLOAT_SELECT_BIT  = 0;
  localparam int DAC_TRIG_BIT      = 0;
  localparam int ADC_TRIG_BIT      = 1;
  localparam int DAC_REF_BIT       = 0;
  localparam int CTRL_MODE_SET_BIT = 7;
  localparam int CTRL_GA_MODE2_BIT = 6;
  localparam int CTRL_GA_MODE1_BIT = 5;
  localparam int CTRL_PA_DIR_BIT   = 4;
  localparam int CTRL_PCH_DIR_BIT  = 3;
  localparam int CTRL_GB_MODE_BIT  = 2;
  localparam int CTRL_PB_DIR_BIT   = 1;
  localparam int CTRL_PCL_DIR_BIT  = 0;
  localparam int ADC_CMD_W         = 5;

  // reset values
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [3:0] RST_DIR_OUT = 4'h0;
  localparam logic [1:0] RST_GA_MODE = 2'h0;

  // group A mode encodings
  localparam logic [1:0] GA_MODE0 = 2'h0;
  localparam logic [1:0] GA_MODE1 = 2'h1;
  localparam logic [1:0] GA_MODE2 = 2'h2;

  // timer clock generation
  localparam int CORE_CLK_HZ = 125_000_000;
  localparam int TCLK_HZ     = 1_000_000;
  localparam int TCLK_DIV    = CORE_CLK_HZ / TCLK_HZ;
  localparam int TCLK_HALF   = TCLK_DIV / 2;
  localparam logic [6:0] TCLK_LAST = 7'(TCLK_DIV - 1);
  localparam logic [6:0] TCLK_HI   = 7'(TCLK_HALF);

  // trigger low pulse from the counter, in ns
  localparam int TRIG_PULSE_NS = 1000;
endpackage

// *** design/bacr_pin_change.sv ***
`timescale 1ns/1ps
module bacr_pin_change
  import bacr_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] pins_i,
  input  wire logic       clear_i,
  output logic      [7:0] flags_o
);
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] prev;
  logic [2:0] fill;

  // two-stage synchroniser, then one stage of history
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= RST_BYTE;
      sync2 <= RST_BYTE;
      prev  <= RST_BYTE;
    end else begin
      sync1 <= pins_i;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // no compare until the pipe holds real pin levels, so pins idling high give no false change
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill <= '0;
    end else begin
      fill <= {fill[1:0], 1'b1};
    end
  end

  // sticky per-bit flags; a change in the clear cycle survives
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          flags_o[g] <= 1'b0;
        end else begin
          flags_o[g] <= (flags_o[g] & ~clear_i) | ((sync2[g] ^ prev[g]) & fill[2]); // RULE_25 RULE_14
        end
      end
    end
  endgenerate
endmodule

// *** design/bacr_top.sv ***
`timescale 1ns/1ps
// Functional notes
// (RULE_01) bit 0 of float control enters float
// (RULE_02) float mode hides newly output port buffers
// (RULE_03) new output port glitches low; float hides
// (RULE_04) control write with bit 7 clear re-enables
// (RULE_05) software loads outputs, rewrites control masked
// (RULE_06) timed adc command keeps low five bits
// (RULE_07) command: range, polarity, three channel bits
// (RULE_08) timed conversions use the stored channel
// (RULE_09) adc trigger enable starts conversion per tick
// (RULE_10) dac trigger enable updates dacs per tick
// (RULE_11) each falling counter pulse is one trigger
// (RULE_12) software rewrites command before next tick
// (RULE_13) change flag set when port c bit changed
// (RULE_14) reading change flags clears them all
// (RULE_15) reset clears dac reference enable
// (RULE_16) software sets reference before dac output
// (RULE_17) software loads dac codes before reference
// (RULE_18) current-loop boards need reference set first
// (RULE_19) counter clocked by 1 MHz, also driven out
// (RULE_20) low gate pauses its counter; pulled high
// (RULE_21) control bit 6 selects mode 2, ignores bit 5
// (RULE_22) dac trigger enable blocks direct dac writes
// (RULE_23) control bit 7 is mode set and float
// (RULE_24) counter pulse low one microsecond is tick
// (RULE_25) port c synchronised, compared, sticky flags
module bacr_top
  import bacr_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] bus_addr_i,
  input  wire logic [7:0] bus_wdata_i,
  input  wire logic       bus_wr_i,
  input  wire logic       bus_rd_i,
  output logic      [7:0] bus_rdata_o,
  input  wire logic [7:0] port_c_pins_i,
  input  wire logic       trigger_counter_out_i,
  input  wire logic [2:0] timer_gate_pins_i,
  output logic      [2:0] timer_gate_o,
  output logic            timer_clk_1mhz_o,
  output logic      [3:0] port_dir_out_o,
  output logic      [3:0] port_buf_en_o,
  output logic      [1:0] group_a_mode_o,
  output logic            group_b_mode_o,
  output logic            adc_start_o,
  output logic      [4:0] adc_cmd_o,
  output logic            dac_update_o,
  output logic            dac_direct_load_o,
  output logic            dac_ref_en_o
);
  // port index: 0 = C low, 1 = B, 2 = C high, 3 = A
  logic                 float_select_bit;
  logic [ADC_CMD_W-1:0] adc_cmd;
  logic                 adc_timer_trigger_enable;
  logic                 dac_timer_trigger_enable;
  logic                 dac_ref;
  logic [3:0]           dir_out;
  logic [3:0]           float_hold;
  logic [1:0]           ga_mode;
  logic                 gb_mode;
  logic [7:0]           pin_change_flag;
  logic                 trig_s1;
  logic                 trig_s2;
  logic                 trig_s3;
  logic                 trig_tick;
  logic [2:0]           gate_s1;
  logic [6:0]           tclk_cnt;
  logic                 wr_ctrl;
  logic                 rd_change;
  logic [3:0]           next_dir_out;
  logic [7:0]           next_rdata;

  // decoded strobes, shared by several processes
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_ctrl   = bus_wr_i & hit(bus_addr_i, OFS_PORT_CTRL);
  assign rd_change = bus_rd_i & hit(bus_addr_i, OFS_PIN_CHANGE);

  // control byte direction bits: 0 means output
  assign next_dir_out = {~bus_wdata_i[CTRL_PA_DIR_BIT], ~bus_wdata_i[CTRL_PCH_DIR_BIT],
                         ~bus_wdata_i[CTRL_PB_DIR_BIT], ~bus_wdata_i[CTRL_PCL_DIR_BIT]};

  // float select register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      float_select_bit <= 1'b0;
    end else if (bus_wr_i && hit(bus_addr_i, OFS_FLOAT_CTRL)) begin
      float_select_bit <= bus_wdata_i[FLOAT_SELECT_BIT]; // RULE_01
    end
  end

  // stored command for timer-started conversions; upper bits dropped
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_cmd <= ADC_CMD_W'(RST_BYTE);
    end else if (bus_wr_i && hit(bus_addr_i, OFS_ADC_CMD)) begin
      adc_cmd <= bus_wdata_i[ADC_CMD_W-1:0]; // RULE_06 RULE_07
    end
  end

  // trigger enables
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_timer_trigger_enable <= 1'b0;
      dac_timer_trigger_enable <= 1'b0;
    end else if (bus_wr_i && hit(bus_addr_i, OFS_TRIG_EN)) begin
      adc_timer_trigger_enable <= bus_wdata_i[ADC_TRIG_BIT];
      dac_timer_trigger_enable <= bus_wdata_i[DAC_TRIG_BIT];
    end
  end

  // reference enable, always off after a board reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_ref <= 1'b0; // RULE_15
    end else if (bus_wr_i && hit(bus_addr_i, OFS_DAC_REF)) begin
      dac_ref <= bus_wdata_i[DAC_REF_BIT];
    end
  end

  // port control snoop: mode set with float, or plain re-enable
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_out    <= RST_DIR_OUT;
      float_hold <= RST_DIR_OUT;
      ga_mode    <= RST_GA_MODE;
      gb_mode    <= 1'b0;
    end else if (wr_ctrl) begin
      if (bus_wdata_i[CTRL_MODE_SET_BIT]) begin // RULE_23
        dir_out <= next_dir_out;
        // only ports that turn into outputs are held off
        float_hold <= float_select_bit ? (next_dir_out & ~dir_out) : RST_DIR_OUT; // RULE_02 RULE_03
        gb_mode    <= bus_wdata_i[CTRL_GB_MODE_BIT];
        if (bus_wdata_i[CTRL_GA_MODE2_BIT]) begin
          ga_mode <= GA_MODE2; // RULE_21
        end else if (bus_wdata_i[CTRL_GA_MODE1_BIT]) begin
          ga_mode <= GA_MODE1;
        end else begin
          ga_mode <= GA_MODE0;
        end
      end else begin
        float_hold <= RST_DIR_OUT; // RULE_04
      end
    end
  end

  // buffer pins follow the port state one cycle later
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_dir_out_o <= RST_DIR_OUT;
      port_buf_en_o  <= RST_DIR_OUT;
      group_a_mode_o <= RST_GA_MODE;
      group_b_mode_o <= 1'b0;
    end else begin
      port_dir_out_o <= dir_out;
      port_buf_en_o  <= dir_out & ~float_hold; // RULE_02 RULE_04
      group_a_mode_o <= ga_mode;
      group_b_mode_o <= gb_mode;
    end
  end

  // counter output synchroniser; third stage only for edge detect
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
    end else begin
      trig_s1 <= trigger_counter_out_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // falling edge of the low pulse is the tick; pulse width is ample
  assign trig_tick = trig_s3 & ~trig_s2; // RULE_11 RULE_24

  // trigger actions and direct dac loads
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_start_o       <= 1'b0;
      dac_update_o      <= 1'b0;
      dac_direct_load_o <= 1'b0;
      adc_cmd_o         <= ADC_CMD_W'(RST_BYTE);
    end else begin
      adc_start_o  <= trig_tick & adc_timer_trigger_enable; // RULE_09
      dac_update_o <= trig_tick & dac_timer_trigger_enable; // RULE_10 RULE_22
      // direct writes are held back while ticks own the update
      dac_direct_load_o <= bus_wr_i & (bus_addr_i >= OFS_DAC_FIRST) & (bus_addr_i <= OFS_DAC_LAST)
                           & ~dac_timer_trigger_enable; // RULE_22
      adc_cmd_o <= adc_cmd; // RULE_08
    end
  end

  // timer clock: 125 cycles per period, slightly asymmetric
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tclk_cnt         <= 7'h00;
      timer_clk_1mhz_o <= 1'b0;
    end else begin
      tclk_cnt         <= (tclk_cnt == TCLK_LAST) ? 7'h00 : tclk_cnt + 7'h01;
      timer_clk_1mhz_o <= (tclk_cnt < TCLK_HI); // RULE_19
    end
  end

  // gate pins to the counters, open gate reads high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gate_s1      <= 3'h7;
      timer_gate_o <= 3'h7;
    end else begin
      gate_s1      <= timer_gate_pins_i;
      timer_gate_o <= gate_s1; // RULE_20
    end
  end

  bacr_pin_change u_pin_change (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins_i     (port_c_pins_i),
    .clear_i    (rd_change),
    .flags_o    (pin_change_flag)
  );

  // read mux; unmapped offsets belong to other blocks and read zero
  always_comb begin
    next_rdata = RST_BYTE;
    case (bus_addr_i)
      OFS_FLOAT_CTRL: next_rdata[FLOAT_SELECT_BIT] = float_select_bit;
      OFS_ADC_CMD:    next_rdata[ADC_CMD_W-1:0] = adc_cmd; // RULE_06
      OFS_TRIG_EN: begin
        next_rdata[ADC_TRIG_BIT] = adc_timer_trigger_enable;
        next_rdata[DAC_TRIG_BIT] = dac_timer_trigger_enable;
      end
      OFS_PIN_CHANGE: next_rdata = pin_change_flag; // RULE_13
      OFS_DAC_REF:    next_rdata[DAC_REF_BIT] = dac_ref;
      default:        next_rdata = RST_BYTE;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_rdata_o  <= RST_BYTE;
      dac_ref_en_o <= 1'b0;
    end else begin
      if (bus_rd_i) begin
        bus_rdata_o <= next_rdata;
      end
      dac_ref_en_o <= dac_ref; // RULE_15
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  float_set_a: assert property ( // RULE_01
    bus_wr_i && bus_addr_i == OFS_FLOAT_CTRL |=> float_select_bit == $past(bus_wdata_i[0]))
    else $error("float select not stored");

  float_hide_a: assert property ( // RULE_02
    wr_ctrl && bus_wdata_i[7] && float_select_bit && !bus_wdata_i[4] && !dir_out[3]
    |-> ##2 port_dir_out_o[3] && !port_buf_en_o[3])
    else $error("new output buffer not floated");

  reenable_a: assert property ( // RULE_04
    wr_ctrl && !bus_wdata_i[7] |-> ##2 port_buf_en_o == port_dir_out_o)
    else $error("buffers not re-enabled");

  cmd_mask_a: assert property ( // RULE_06
    bus_wr_i && bus_addr_i == OFS_ADC_CMD ##2 bus_rd_i && bus_addr_i == OFS_ADC_CMD
    |=> bus_rdata_o == {3'h0, $past(bus_wdata_i[4:0], 3)})
    else $error("command byte readback wrong");

  adc_tick_a: assert property ( // RULE_09
    trig_tick && adc_timer_trigger_enable |=> adc_start_o && adc_cmd_o == $past(adc_cmd))
    else $error("tick did not start conversion");

  dac_block_a: assert property ( // RULE_22
    bus_wr_i && bus_addr_i == OFS_DAC_FIRST && dac_timer_trigger_enable |=> !dac_direct_load_o)
    else $error("direct dac load while triggered");

  change_clear_a: assert property ( // RULE_14
    rd_change && pin_change_flag != 8'h00 && (u_pin_change.sync2 == u_pin_change.prev)
    |=> pin_change_flag == 8'h00)
    else $error("change flags not cleared");

  ref_reset_a: assert property ( // RULE_15
    $fell(rst_i) |-> !dac_ref_en_o)
    else $error("reference on after reset");

  tclk_period_a: assert property ( // RULE_19
    $rose(timer_clk_1mhz_o) |-> ##125 $rose(timer_clk_1mhz_o))
    else $error("timer clock period wrong");

  mode2_a: assert property ( // RULE_21
    wr_ctrl && bus_wdata_i[7] && bus_wdata_i[6] |-> ##2 group_a_mode_o == GA_MODE2)
    else $error("group a mode 2 not selected");

  dac_tick_a: assert property ( // RULE_10
    trig_tick && dac_timer_trigger_enable |=> dac_update_o)
    else $error("tick did not update dacs");

  adc_off_a: assert property ( // RULE_09
    trig_tick && !adc_timer_trigger_enable |=> !adc_start_o)
    else $error("conversion started while disabled");

  tick_once_a: assert property ( // RULE_11
    adc_start_o || dac_update_o |=> !adc_start_o && !dac_update_o)
    else $error("one tick gave two pulses");

  direct_load_a: assert property ( // RULE_22
    bus_wr_i && bus_addr_i == OFS_DAC_FIRST && !dac_timer_trigger_enable |=> dac_direct_load_o)
    else $error("direct dac load missing");

  ref_store_a: assert property ( // RULE_16
    bus_wr_i && bus_addr_i == OFS_DAC_REF |-> ##2 dac_ref_en_o == $past(bus_wdata_i[0], 2))
    else $error("reference enable not stored");

  group_b_a: assert property ( // RULE_23
    wr_ctrl && bus_wdata_i[7] |-> ##2 group_b_mode_o == $past(bus_wdata_i[2], 2))
    else $error("group b mode not loaded");

  flag_keep_a: assert property ( // RULE_14
    !rd_change |=> (pin_change_flag & $past(pin_change_flag)) == $past(pin_change_flag))
    else $error("change flag lost without read");

  float_off_a: assert property ( // RULE_01
    wr_ctrl && bus_wdata_i[7] && !float_select_bit |-> ##2 port_buf_en_o == port_dir_out_o)
    else $error("buffer held off outside float mode");

  tclk_high_a: assert property ( // RULE_19
    $rose(timer_clk_1mhz_o) |-> ##62 $fell(timer_clk_1mhz_o))
    else $error("timer clock high time wrong");

  float_seq_c: cover property (
    wr_ctrl && float_select_bit && bus_wdata_i[7] ##[1:20] wr_ctrl && !bus_wdata_i[7]);
  tick_both_c: cover property (adc_start_o && dac_update_o);
  change_read_c: cover property (rd_change && pin_change_flag != 8'h00);
  held_off_c: cover property (port_dir_out_o != 4'h0 && port_buf_en_o == 4'h0);
  ref_on_c: cover property (dac_ref_en_o);
endmodule

// *** verification/bacr_trig_model.sv ***
`timescale 1ns/1ps
module bacr_trig_model #(
  parameter int RATE = 5
) (
  input  wire logic tclk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic gate_i,
  output logic      out_o
);
  int unsigned cnt;

  // rate generator: one low tick every RATE clocks, one clock (1 us) wide
  always_ff @(posedge tclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      out_o <= 1'b1;
    end else if (!run_i) begin
      cnt <= 0;
      out_o <= 1'b1; // idle line sits high
    end else if (!gate_i) begin
      out_o <= 1'b1; // paused: count held, output forced high
    end else begin
      cnt <= (cnt == RATE - 1) ? 0 : cnt + 1;
      out_o <= (cnt != RATE - 1);
    end
  end
endmodule

// *** verification/bacr_bench.sv ***
`timescale 1ns/1ps
module bacr_bench;
  import bacr_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] pc = 8'h00;
  logic [2:0] gates = 3'h7;
  logic       run = 1'b0;
  logic       trig;
  logic       tclk;
  logic [7:0] rdata;
  logic [2:0] gate_o;
  logic [3:0] dir_o;
  logic [3:0] buf_o;
  logic [1:0] ga_o;
  logic       gb_o;
  logic       adc_st;
  logic [4:0] cmd_o;
  logic       dac_up;
  logic       dload;
  logic       ref_o;
  logic [7:0] exp_cmd = 8'h00;
  int         fail_count = 0;
  int         n_tests = 0;
  int         adc_cnt = 0;
  int         dac_cnt = 0;
  int         ld_cnt = 0;

  bacr_top bacr_top_inst (.core_clk_i(clk), .rst_i(rst), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .port_c_pins_i(pc), .trigger_counter_out_i(trig),
    .timer_gate_pins_i(gates), .timer_gate_o(gate_o), .timer_clk_1mhz_o(tclk), .port_dir_out_o(dir_o),
    .port_buf_en_o(buf_o), .group_a_mode_o(ga_o), .group_b_mode_o(gb_o), .adc_start_o(adc_st),
    .adc_cmd_o(cmd_o), .dac_update_o(dac_up), .dac_direct_load_o(dload), .dac_ref_en_o(ref_o));

  bacr_trig_model bacr_trig_model_inst (.tclk_i(tclk), .rst_i(rst), .run_i(run), .gate_i(gate_o[1]),
    .out_o(trig));

  // 125 MHz board clock
  always #4 clk = ~clk;

  // pulse counters, sampled on the falling edge where outputs are settled
  always @(negedge clk) begin
    if (adc_st === 1'b1) begin
      adc_cnt++;
      chk(8'(cmd_o), exp_cmd, "timed cmd");
    end
    if (dac_up === 1'b1) dac_cnt++;
    if (dload === 1'b1) ld_cnt++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data is registered one cycle after the strobe edge, then stands
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1;
    chk(rdata, exp, msg);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_dac(input int n);
    int t;
    t = dac_cnt + n;
    for (int i = 0; i < 3000 && dac_cnt < t; i++) @(posedge clk);
    chk(8'(dac_cnt >= t), 8'h01, "tick wait");
  endtask

  task automatic t_reset();
    for (int a = 20; a < 25; a++) rd_chk(5'(a), 8'h00, "reset value");
    chk(8'(ref_o), 8'h00, "ref at reset");
    chk(8'(gate_o), 8'h07, "gates idle");
  endtask

  task automatic t_regs();
    wr_reg(OFS_ADC_CMD, 8'hFF);
    rd_chk(OFS_ADC_CMD, 8'h1F, "cmd low five bits");
    wr_reg(5'h1F, 8'hFF);
    rd_chk(5'h1F, 8'h00, "unmapped read");
    @(posedge clk);
    gates <= 3'h5;
    settle();
    chk(8'(gate_o), 8'h05, "gate pass");
    @(posedge clk);
    gates <= 3'h7;
  endtask

  task automatic t_ref();
    for (int a = 4; a < 12; a++) wr_reg(5'(a), 8'h00);
    wr_reg(OFS_DAC_REF, 8'h01);
    settle();
    chk(8'(ref_o), 8'h01, "ref on");
    rd_chk(OFS_DAC_REF, 8'h01, "ref read");
    @(posedge clk);
    rst <= 1'b1;
    // pins sit high across the reset: no false change may follow the release
    pc <= 8'hC3;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(8'(ref_o), 8'h00, "ref after reset");
    rd_chk(OFS_DAC_REF, 8'h00, "ref read after reset");
  endtask

  task automatic t_float();
    wr_reg(OFS_FLOAT_CTRL, 8'hFF);
    rd_chk(OFS_FLOAT_CTRL, 8'h01, "float select");
    wr_reg(OFS_PORT_CTRL, 8'h80);
    settle();
    chk(8'(dir_o), 8'h0F, "all output");
    chk(8'(buf_o), 8'h00, "buffers held off");
    for (int a = 16; a < 19; a++) wr_reg(5'(a), 8'hFF);
    wr_reg(OFS_PORT_CTRL, 8'h80 & 8'h7F);
    settle();
    chk(8'(buf_o), 8'h0F, "buffers re-enabled");
    chk(8'(dir_o), 8'h0F, "dirs kept");
    wr_reg(OFS_FLOAT_CTRL, 8'h00);
    wr_reg(OFS_PORT_CTRL, 8'h9B);
    settle();
    chk(8'(dir_o), 8'h00, "all input");
    wr_reg(OFS_PORT_CTRL, 8'hE0);
    settle();
    chk(8'(buf_o), 8'h0F, "no float, driven");
    chk(8'(ga_o), 8'(GA_MODE2), "group a mode 2");
    wr_reg(OFS_PORT_CTRL, 8'hA4);
    settle();
    chk(8'(gb_o), 8'h01, "group b mode 1");
    chk(8'(ga_o), 8'(GA_MODE1), "group a mode 1");
  endtask

  // toggling back to the start level must still leave the flag set
  task automatic t_pinchg();
    repeat (4) begin
      @(posedge clk);
      pc <= pc ^ 8'h04;
      repeat (3) @(posedge clk);
    end
    settle();
    rd_chk(OFS_PIN_CHANGE, 8'h04, "flag sticky");
    rd_chk(OFS_PIN_CHANGE, 8'h00, "read clears");
    repeat (3) begin
      @(posedge clk);
      pc <= pc ^ 8'h20;
      repeat (3) @(posedge clk);
    end
    settle();
    rd_chk(OFS_PIN_CHANGE, 8'h20, "only new bit");
  endtask

  task automatic t_tclk();
    int hi;
    int lo;
    for (int i = 0; i < 200 && tclk === 1'b1; i++) @(negedge clk);
    for (int i = 0; i < 200 && tclk === 1'b0; i++) @(negedge clk);
    for (hi = 0; hi < 200 && tclk === 1'b1; hi++) @(negedge clk);
    for (lo = 0; lo < 200 && tclk === 1'b0; lo++) @(negedge clk);
    chk(8'(hi + lo), 8'(TCLK_DIV), "1 MHz period");
    chk(8'(hi), 8'h3E, "high time");
  endtask

  task automatic t_trig();
    int a0;
    int d0;
    int l0;
    l0 = ld_cnt;
    wr_reg(OFS_DAC_FIRST, 8'h55);
    settle();
    chk(8'(ld_cnt - l0), 8'h01, "direct load");
    exp_cmd = 8'h0B;
    wr_reg(OFS_ADC_CMD, 8'h0B);
    wr_reg(OFS_TRIG_EN, 8'h03);
    a0 = adc_cnt;
    d0 = dac_cnt;
    run <= 1'b1;
    wait_dac(1);
    exp_cmd = 8'h12;
    wr_reg(OFS_ADC_CMD, 8'h12);
    wait_dac(1);
    chk(8'(adc_cnt - a0), 8'h02, "adc ticks");
    chk(8'(dac_cnt - d0), 8'h02, "dac ticks");
    l0 = ld_cnt;
    wr_reg(OFS_DAC_FIRST, 8'hAA);
    settle();
    chk(8'(ld_cnt - l0), 8'h00, "direct load blocked");
    wr_reg(OFS_TRIG_EN, 8'h01);
    a0 = adc_cnt;
    wait_dac(2);
    chk(8'(adc_cnt - a0), 8'h00, "adc disabled");
    gates <= 3'h5;
    wr_reg(OFS_TRIG_EN, 8'h03);
    d0 = dac_cnt;
    repeat (1500) @(posedge clk);
    chk(8'(dac_cnt - d0), 8'h00, "gate paused");
    gates <= 3'h7;
    wr_reg(OFS_TRIG_EN, 8'h00);
    d0 = dac_cnt;
    repeat (1300) @(posedge clk);
    chk(8'(dac_cnt - d0), 8'h00, "dac disabled");
    run <= 1'b0;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_ref();
    t_float();
    t_pinchg();
    t_tclk();
    t_trig();
    wrap_up();
  end

  // watchdog, well past the expected run of about 6000 cycles
  initial begin
    #500000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    wrap_up();
  end
endmodule
